// ### verilog/dtmr_top.sv
// Pin routing and configuration registers of the two 16-bit timers.
// Assumes the core presents a mode selector and a port-indexed move strobe.
`timescale 1ns/1ps
`default_nettype none
module dtmr_top (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic [4:0] I_MODE_SEL,
   input wire logic I_MOVE_B,
   input wire logic I_MOVE_C,
   input wire logic [7:0] I_WDATA,
   input wire logic [7:0] I_RT_COUNTER,
   input wire logic I_RT_TICK,
   input wire logic I_PORTB_BIT4,
   input wire logic I_PORTB_BIT5,
   input wire logic I_PORTB_BIT7,
   input wire logic I_PORTC_BIT0,
   input wire logic I_PORTC_BIT1,
   input wire logic I_PORTC_BIT3,
   input wire logic I_T1_WAVE,
   input wire logic I_T2_WAVE,
   output logic [7:0] O_RDATA,
   output logic O_PORTB_BIT6,
   output logic O_PORTC_BIT2,
   output logic [1:0] O_T1_MODE,
   output logic [1:0] O_T2_MODE,
   output logic O_T1_TICK,
   output logic O_T2_TICK,
   output logic O_T1_CAP1,
   output logic O_T1_CAP2,
   output logic O_T2_CAP1,
   output logic O_T2_CAP2,
   output logic O_T1_EVENT,
   output logic O_T2_EVENT
);
   // -----------------------------------------------------------------
   // Register access decode
   // -----------------------------------------------------------------
   logic wr1;
   logic wr2;
   logic [6:0] cfg1;
   logic [6:0] cfg2;
   logic tick1;
   logic tick2;
   logic wrap_flag;
   logic next_wrap_flag;
   logic [7:0] rdata;
   logic [7:0] next_rdata;
   logic wrap_evt;
   logic clr_wrap;
   assign wr1 = I_MOVE_B && (I_MODE_SEL == dtmr_pkg::SEL_WRITE_CFG);
   assign wr2 = I_MOVE_C && (I_MODE_SEL == dtmr_pkg::SEL_WRITE_CFG);
   dtmr_cfg u_cfg1 (
      .i_clk(I_CLK),
      .i_rst_b(I_RST_B),
      .i_wr(wr1),
      .i_wdata(I_WDATA[6:0]),
      .o_cfg(cfg1),
      .o_tick(tick1)
   );
   dtmr_cfg u_cfg2 (
      .i_clk(I_CLK),
      .i_rst_b(I_RST_B),
      .i_wr(wr2),
      .i_wdata(I_WDATA[6:0]),
      .o_cfg(cfg2),
      .o_tick(tick2)
   );
   // -----------------------------------------------------------------
   // Real-time counter wrap flag and read data
   // -----------------------------------------------------------------
   always_comb begin
      wrap_evt = I_RT_TICK && (I_RT_COUNTER == dtmr_pkg::RTC_WRAP_FROM);
      clr_wrap = wr1 && !I_WDATA[dtmr_pkg::CFG_WRAP_BIT];
      next_wrap_flag = wrap_flag;
      if (wrap_evt) begin
         next_wrap_flag = 1'b1;
      end else if (clr_wrap) begin
         next_wrap_flag = 1'b0;
      end
      next_rdata = rdata;
      if (I_MODE_SEL == dtmr_pkg::SEL_READ_CFG) begin
         if (I_MOVE_B) begin
            next_rdata = {wrap_flag, cfg1};
         end else if (I_MOVE_C) begin
            next_rdata = {1'b0, cfg2};
         end
      end
   end
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         wrap_flag <= 1'b0;
         rdata <= 8'h00;
      end else begin
         wrap_flag <= next_wrap_flag;
         rdata <= next_rdata;
      end
   end
   assign O_RDATA = rdata;
   // -----------------------------------------------------------------
   // Pin synchronisers and edge selection
   // -----------------------------------------------------------------
   logic [5:0] pins;
   logic [5:0] rise;
   logic [5:0] edges;
   assign pins = {I_PORTC_BIT3, I_PORTC_BIT1, I_PORTC_BIT0, I_PORTB_BIT7, I_PORTB_BIT5, I_PORTB_BIT4};
   assign rise = {cfg2[dtmr_pkg::CFG_EVT_EDGE_BIT], {2{cfg2[dtmr_pkg::CFG_CAP_EDGE_BIT]}},
                  cfg1[dtmr_pkg::CFG_EVT_EDGE_BIT], {2{cfg1[dtmr_pkg::CFG_CAP_EDGE_BIT]}}};
   genvar g;
   generate
      for (g = 0; g < 6; g++) begin : g_sync
         dtmr_sync u_sync (
            .i_clk(I_CLK),
            .i_rst_b(I_RST_B),
            .i_pin(pins[g]),
            .i_rise_sel(rise[g]),
            .o_level(),
            .o_edge(edges[g])
         );
      end
   endgenerate
   // -----------------------------------------------------------------
   // Mode-dependent outputs
   // -----------------------------------------------------------------
   logic [1:0] mode1;
   logic [1:0] mode2;
   logic [12:0] next_outs;
   logic [12:0] outs;
   assign mode1 = cfg1[dtmr_pkg::CFG_MODE_MSB:dtmr_pkg::CFG_MODE_LSB];
   assign mode2 = cfg2[dtmr_pkg::CFG_MODE_MSB:dtmr_pkg::CFG_MODE_LSB];
   always_comb begin
      next_outs = 13'h0000;
      next_outs[0] = (mode1 == dtmr_pkg::DTMR_WAVEFORM) || (mode1 == dtmr_pkg::DTMR_CAPTURE) ? I_T1_WAVE : 1'b0;
      next_outs[1] = (mode2 == dtmr_pkg::DTMR_WAVEFORM) || (mode2 == dtmr_pkg::DTMR_CAPTURE) ? I_T2_WAVE : 1'b0;
      next_outs[2] = (mode1 == dtmr_pkg::DTMR_EVENT) ? edges[2] : tick1;
      next_outs[3] = (mode2 == dtmr_pkg::DTMR_EVENT) ? edges[5] : tick2;
      next_outs[4] = (mode1 == dtmr_pkg::DTMR_CAPTURE) && edges[0];
      next_outs[5] = (mode1 == dtmr_pkg::DTMR_CAPTURE) && edges[1];
      next_outs[6] = (mode2 == dtmr_pkg::DTMR_CAPTURE) && edges[3];
      next_outs[7] = (mode2 == dtmr_pkg::DTMR_CAPTURE) && edges[4];
      next_outs[8] = (mode1 == dtmr_pkg::DTMR_EVENT) && edges[2];
      next_outs[9] = (mode2 == dtmr_pkg::DTMR_EVENT) && edges[5];
   end
   always_ff @(posedge I_CLK) begin
      if (!I_RST_B) begin
         outs <= 13'h0000;
      end else begin
         outs <= next_outs;
      end
   end
   assign O_PORTB_BIT6 = outs[0];
   assign O_PORTC_BIT2 = outs[1];
   assign O_T1_TICK = outs[2];
   assign O_T2_TICK = outs[3];
   assign O_T1_CAP1 = outs[4];
   assign O_T1_CAP2 = outs[5];
   assign O_T2_CAP1 = outs[6];
   assign O_T2_CAP2 = outs[7];
   assign O_T1_EVENT = outs[8];
   assign O_T2_EVENT = outs[9];
   assign O_T1_MODE = mode1;
   assign O_T2_MODE = mode2;
endmodule // dtmr_top
`default_nettype wire

// ### verilog/dtmr_pkg.sv
// Package for the dual timer pin routing and configuration block.
// Assumes a single 10 MHz system clock and a synchronous active-low reset.
`default_nettype none
package dtmr_pkg;
   // -----------------------------------------------------------------
   // Mode selector values for indirect register access
   // -----------------------------------------------------------------
   localparam logic [4:0] SEL_READ_CFG = 5'h06;
   localparam logic [4:0] SEL_WRITE_CFG = 5'h16;
   // -----------------------------------------------------------------
   // Configuration register fields
   // -----------------------------------------------------------------
   localparam int CFG_WRAP_BIT = 7;
   localparam int CFG_CAP_EDGE_BIT = 6;
   localparam int CFG_EVT_EDGE_BIT = 5;
   localparam int CFG_PS_LSB = 2;
   localparam int CFG_PS_MSB = 4;
   localparam int CFG_MODE_LSB = 0;
   localparam int CFG_MODE_MSB = 1;
   localparam logic [7:0] CFG_RESET = 8'h00;
   localparam logic [7:0] RTC_WRAP_FROM = 8'hFF;
   localparam int SYNC_STAGES = 3;
   typedef enum logic [1:0] {
      DTMR_SW_TIMER,
      DTMR_WAVEFORM,
      DTMR_CAPTURE,
      DTMR_EVENT
   } dtmr_mode_t;
endpackage
`default_nettype wire

// ### verilog/dtmr_sync.sv
// Three-stage input synchroniser with edge detection.
// Assumes an asynchronous pin input and the system clock.
`timescale 1ns/1ps
`default_nettype none
module dtmr_sync (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_pin,
   input wire logic i_rise_sel,
   output logic o_level,
   output logic o_edge
);
   logic [2:0] stage;
   logic [2:0] next_stage;
   always_comb begin
      next_stage = {stage[1:0], i_pin};
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         stage <= 3'h0;
      end else begin
         stage <= next_stage;
      end
   end
   // Stage 2 and 3 compared only; stage 1 feeds stage 2 alone.
   assign o_level = stage[2];
   assign o_edge = i_rise_sel ? (stage[1] & ~stage[2]) : (~stage[1] & stage[2]);
endmodule // dtmr_sync
`default_nettype wire

// ### verilog/dtmr_cfg.sv
// One timer's configuration register with its prescale decoding; edge selection is decoded in the top level.
// Assumes pins already synchronised by the top level.
`timescale 1ns/1ps
`default_nettype none
module dtmr_cfg (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_wr,
   input wire logic [6:0] i_wdata,
   output logic [6:0] o_cfg,
   output logic o_tick
);
   logic [6:0] cfg;
   logic [6:0] next_cfg;
   logic [6:0] div;
   logic [6:0] next_div;
   logic [2:0] ps;
   always_comb begin
      next_cfg = i_wr ? i_wdata : cfg;
      ps = cfg[dtmr_pkg::CFG_PS_MSB:dtmr_pkg::CFG_PS_LSB];
      next_div = div + 7'h01;
   end
   always_ff @(posedge i_clk) begin
      if (!i_rst_b) begin
         cfg <= dtmr_pkg::CFG_RESET[6:0];
         div <= 7'h00;
      end else begin
         cfg <= next_cfg;
         div <= next_div;
      end
   end
   // Tick once every 2**ps system clocks.
   assign o_tick = (ps == 3'h0) ? 1'b1 : ((div & ((7'h01 << ps) - 7'h01)) == 7'h00);
   assign o_cfg = cfg;
endmodule // dtmr_cfg
`default_nettype wire

// ### dv/dtmr_pins.sv
// Model of the external capture and event signals.
// Assumes the bench requests a level change one cycle ahead.
`timescale 1ns/1ps
`default_nettype none
module dtmr_pins (
   input wire logic i_clk,
   input wire logic [5:0] i_tog,
   output logic [5:0] o_pin
);
   initial o_pin = 6'h00;
   // Each requested pin changes level once, a clean edge.
   always @(posedge i_clk) begin
      o_pin <= o_pin ^ i_tog;
   end
endmodule // dtmr_pins
`default_nettype wire

// ### dv/dtmr_top_properties.sv
// Checker of the timer configuration block.
// Assumes it is bound to dtmr_top.
`timescale 1ns/1ps
`default_nettype none
module dtmr_top_chk (
   input wire logic I_CLK,
   input wire logic I_RST_B,
   input wire logic [4:0] I_MODE_SEL,
   input wire logic I_MOVE_B,
   input wire logic I_MOVE_C,
   input wire logic [7:0] I_WDATA,
   input wire logic [7:0] I_RT_COUNTER,
   input wire logic I_RT_TICK,
   input wire logic I_T1_WAVE,
   input wire logic [7:0] O_RDATA,
   input wire logic O_PORTB_BIT6,
   input wire logic [1:0] O_T1_MODE,
   input wire logic O_T1_CAP1,
   input wire logic O_T1_EVENT
);
   wire wr1 = I_MODE_SEL == dtmr_pkg::SEL_WRITE_CFG && I_MOVE_B;
   wire rdx = I_MODE_SEL == dtmr_pkg::SEL_READ_CFG;
   wire wv = O_T1_MODE == 2'h1 || O_T1_MODE == 2'h2;
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_RST_B);
   sequence s_wrap; I_RT_TICK && I_RT_COUNTER == dtmr_pkg::RTC_WRAP_FROM; endsequence
   sequence s_rd1; rdx && I_MOVE_B; endsequence
   property p_wr1; wr1 |=> O_T1_MODE == $past(I_WDATA[1:0]); endproperty
   a_wr1: assert property (p_wr1) else $error("mode write lost");
   property p_rdh; !(rdx && (I_MOVE_B || I_MOVE_C)) |=> $stable(O_RDATA); endproperty
   a_rdh: assert property (p_rdh) else $error("read data moved");
   property p_rd2; rdx && I_MOVE_C && !I_MOVE_B |=> !O_RDATA[7]; endproperty
   a_rd2: assert property (p_rd2) else $error("flag on timer two");
   property p_wrap; s_wrap ##1 !wr1 ##1 s_rd1 |=> O_RDATA[7]; endproperty
   a_wrap: assert property (p_wrap) else $error("wrap flag unset");
   property p_wv; wv |=> O_PORTB_BIT6 == $past(I_T1_WAVE); endproperty
   a_wv: assert property (p_wv) else $error("wave not routed");
   property p_wv0; !wv |=> !O_PORTB_BIT6; endproperty
   a_wv0: assert property (p_wv0) else $error("wave leaks");
   property p_cap; O_T1_CAP1 |-> $past(O_T1_MODE) == 2'h2; endproperty
   a_cap: assert property (p_cap) else $error("capture off mode");
   property p_evt; O_T1_EVENT |-> $past(O_T1_MODE) == 2'h3; endproperty
   a_evt: assert property (p_evt) else $error("event off mode");
endmodule // dtmr_top_chk
bind dtmr_top dtmr_top_chk u_chk (.*);
`default_nettype wire

// ### dv/testbench.sv
// Bench of the timer configuration block.
// Assumes dtmr_pins drives the pins.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic mb = 1'b0;
   logic mc = 1'b0;
   logic rt = 1'b0;
   logic [1:0] wv = 2'h0;
   logic [4:0] sel = 5'h00;
   logic [7:0] wd = 8'h00;
   logic [7:0] rc = 8'h00;
   logic [7:0] rdat, pul;
   logic [5:0] tog = 6'h00;
   logic [5:0] pin;
   logic [1:0] wo, m1, m2;
   int cnt[8];
   int ps[3] = '{0, 2, 7};
   int n_fail = 0;
   int checks_done = 0;
   localparam logic [4:0] W = dtmr_pkg::SEL_WRITE_CFG;
   initial forever #50 clk = ~clk;
   dtmr_pins PINS (.i_clk(clk), .i_tog(tog), .o_pin(pin));
   dtmr_top DUT (.I_CLK(clk), .I_RST_B(rst_b), .I_MODE_SEL(sel), .I_MOVE_B(mb), .I_MOVE_C(mc), .I_WDATA(wd),
      .I_RT_COUNTER(rc), .I_RT_TICK(rt), .I_PORTB_BIT4(pin[0]), .I_PORTB_BIT5(pin[1]), .I_PORTB_BIT7(pin[2]),
      .I_PORTC_BIT0(pin[3]), .I_PORTC_BIT1(pin[4]), .I_PORTC_BIT3(pin[5]), .I_T1_WAVE(wv[0]), .I_T2_WAVE(wv[1]),
      .O_RDATA(rdat), .O_PORTB_BIT6(wo[0]), .O_PORTC_BIT2(wo[1]), .O_T1_MODE(m1), .O_T2_MODE(m2),
      .O_T1_TICK(pul[0]), .O_T2_TICK(pul[1]), .O_T1_CAP1(pul[2]), .O_T1_CAP2(pul[3]), .O_T2_CAP1(pul[4]),
      .O_T2_CAP2(pul[5]), .O_T1_EVENT(pul[6]), .O_T2_EVENT(pul[7]));
   always @(posedge clk) for (int i = 0; i < 8; i++) if (pul[i] === 1'b1) cnt[i]++;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic c, input logic [4:0] s, input logic [7:0] d);
      @(negedge clk);
      sel = s;
      wd = d;
      mb = !c;
      mc = c;
      @(negedge clk);
      mb = 1'b0;
      mc = 1'b0;
   endtask
   task automatic rd(input logic c, input logic [7:0] exp);
      acc(c, dtmr_pkg::SEL_READ_CFG, 8'h00);
      chk(rdat, exp);
   endtask
   task automatic ev(input logic [5:0] t, input logic k, input logic [7:0] r);
      @(negedge clk);
      tog = t;
      rt = k;
      rc = r;
      @(negedge clk);
      tog = 6'h00;
      rt = 1'b0;
      if (!k) repeat (8) @(negedge clk);
   endtask
   task automatic clr;
      repeat (2) @(negedge clk);
      cnt = '{default: 0};
   endtask
   task automatic cc(input logic [7:0] e);
      for (int i = 2; i < 8; i++) chk(8'(cnt[i]), {7'h00, e[i]});
   endtask
   task automatic test_done;
      if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      n_fail++;
      test_done;
   end
   initial begin
      repeat (20) @(negedge clk);
      rst_b = 1'b1;
      rd(1'b0, dtmr_pkg::CFG_RESET);
      rd(1'b1, dtmr_pkg::CFG_RESET);
      for (int m = 0; m < 4; m++) begin
         acc(1'b0, W, 8'h7C | 8'(m));
         acc(1'b1, W, 8'h7F ^ 8'(m));
         rd(1'b0, 8'h7C | 8'(m));
         chk({4'h0, m1, m2}, {4'h0, 2'(m), ~2'(m)});
      end
      acc(1'b0, 5'h12, 8'h00);
      acc(1'b1, W, 8'hFC);
      rd(1'b0, 8'h7F);
      rd(1'b1, 8'h7C);
      ev(6'h00, 1'b1, 8'hFE);
      rd(1'b0, 8'h7F);
      ev(6'h00, 1'b1, 8'hFF);
      rd(1'b0, 8'hFF);
      acc(1'b0, W, 8'h7F);
      rd(1'b0, 8'h7F);
      foreach (ps[i]) begin
         acc(1'b0, W, 8'(ps[i] << 2));
         acc(1'b1, W, 8'(ps[i] << 2));
         clr;
         repeat (128) @(negedge clk);
         chk(8'(cnt[0]), 8'(128 >> ps[i]));
         chk(8'(cnt[1]), 8'(128 >> ps[i]));
      end
      acc(1'b0, W, 8'h42);
      acc(1'b1, W, 8'h02);
      clr;
      ev(6'h3F, 1'b0, 8'h00);
      cc(8'h0C);
      ev(6'h3F, 1'b0, 8'h00);
      cc(8'h3C);
      acc(1'b0, W, 8'h23);
      acc(1'b1, W, 8'h03);
      clr;
      ev(6'h3F, 1'b0, 8'h00);
      cc(8'h40);
      ev(6'h3F, 1'b0, 8'h00);
      cc(8'hC0);
      acc(1'b0, W, 8'h01);
      acc(1'b1, W, 8'h00);
      wv = 2'h3;
      repeat (3) @(negedge clk);
      chk({6'h00, wo}, 8'h01);
      acc(1'b1, W, 8'h02);
      repeat (2) @(negedge clk);
      chk({6'h00, wo}, 8'h03);
      test_done;
   end
endmodule // testbench
`default_nettype wire
